// File: pkg/pio_pkg.sv
// Constants shared by the parallel port control block
package pio_pkg;

  // ==========================================================================
  // Host bus and address layout
  // ==========================================================================
  localparam int          PIO_DW          = 8;
  localparam int          PIO_AW          = 8;
  localparam int          PIO_MAX_PORTS   = 4;
  localparam int          PIO_SEC_PER_PRT = 2;
  localparam int          PIO_BOARD_LSB   = 4;
  localparam int          PIO_BOARD_MSB   = 7;
  localparam int          PIO_PORT_LSB    = 2;
  localparam int          PIO_PORT_MSB    = 3;
  localparam int          PIO_SEC_BIT     = 1;
  localparam int          PIO_CHAN_BIT    = 0;
  localparam int          PIO_SEC_LSB     = 1;
  localparam int          PIO_SEC_MSB     = 3;

  // Channel offsets within a port
  localparam logic [1:0]  PIO_OFF_A_CTL   = 2'h0;
  localparam logic [1:0]  PIO_OFF_A_DATA  = 2'h1;
  localparam logic [1:0]  PIO_OFF_B_CTL   = 2'h2;
  localparam logic [1:0]  PIO_OFF_B_DATA  = 2'h3;

  // Host transfer opcodes, used only by the host
  localparam logic [7:0]  PIO_OP_INPUT    = 8'hDB;
  localparam logic [7:0]  PIO_OP_OUTPUT   = 8'hD3;

  // ==========================================================================
  // Control/status register fields
  // ==========================================================================
  localparam int          PIO_B_FLAG1     = 7;
  localparam int          PIO_B_FLAG2     = 6;
  localparam int          PIO_B_L2_DIR    = 5;
  localparam int          PIO_B_L2_LVL    = 4;
  localparam int          PIO_B_L2_IEN    = 3;
  localparam int          PIO_B_ROUTE     = 2;
  localparam int          PIO_B_L1_LVL    = 1;
  localparam int          PIO_B_L1_IEN    = 0;
  localparam int          PIO_CTL_LO_W    = 6;

  localparam logic [5:0]  PIO_CTL_RST     = 6'h00;
  localparam logic [7:0]  PIO_DDR_RST     = 8'h00;
  localparam logic [7:0]  PIO_OUT_RST     = 8'h00;
  localparam logic [7:0]  PIO_RD_IDLE     = 8'h00;

endpackage : pio_pkg

// File: pkg/pio_sec_if.sv
// Carrier between the port decoder and one section
`timescale 1ns/1ps
interface pio_sec_if;
  logic       wr_ctl;
  logic       wr_data;
  logic       rd_data;
  logic       ev1;
  logic       ev2;
  logic [7:0] wdata;
  logic [7:0] pins_s;
  logic [7:0] ctl;
  logic [7:0] ddr;
  logic [7:0] outr;
  logic [7:0] rdval;
  logic       irq_n;
  logic       hs2_out;
  logic       hs2_oe;

  modport dec (output wr_ctl, wr_data, rd_data, ev1, ev2, wdata, pins_s,
               input  ctl, ddr, outr, rdval, irq_n, hs2_out, hs2_oe);
  modport sec (input  wr_ctl, wr_data, rd_data, ev1, ev2, wdata, pins_s,
               output ctl, ddr, outr, rdval, irq_n, hs2_out, hs2_oe);
endinterface : pio_sec_if

// File: logic/pio_section.sv
// One port section: control/status, direction and output registers
`timescale 1ns/1ps
module pio_section
  import pio_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  pio_sec_if.sec   s
);

  logic [PIO_CTL_LO_W-1:0] ctl_lo_q;
  logic                    flag1_q;
  logic                    flag2_q;
  logic [7:0]              ddr_q;
  logic [7:0]              out_q;
  logic                    irq_n_q;
  logic                    hs2_out_q;
  logic                    hs2_oe_q;
  logic                    rd_clr;

  // Only a read of the data register, not the direction register, clears
  assign rd_clr = s.rd_data & ctl_lo_q[PIO_B_ROUTE];

  // ==========================================================================
  // Control bits
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_lo_q <= PIO_CTL_RST;
    end else if (s.wr_ctl) begin
      ctl_lo_q <= s.wdata[PIO_CTL_LO_W-1:0];
    end
  end

  // ==========================================================================
  // Status flags: set wins over the clear of the same cycle
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      flag1_q <= 1'b0;
    end else if (s.ev1) begin
      flag1_q <= 1'b1;
    end else if (rd_clr) begin
      flag1_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flag2_q <= 1'b0;
    end else if (s.ev2 && !ctl_lo_q[PIO_B_L2_DIR]) begin
      flag2_q <= 1'b1;
    end else if (rd_clr) begin
      flag2_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Direction and output data
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      ddr_q <= PIO_DDR_RST;
    end else if (s.wr_data && !ctl_lo_q[PIO_B_ROUTE]) begin
      ddr_q <= s.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_q <= PIO_OUT_RST;
    end else if (s.wr_data && ctl_lo_q[PIO_B_ROUTE]) begin
      out_q <= s.wdata;
    end
  end

  // ==========================================================================
  // Request line and line two drive
  // ==========================================================================
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= !((flag1_q && ctl_lo_q[PIO_B_L1_IEN]) ||
                   (flag2_q && ctl_lo_q[PIO_B_L2_IEN] && !ctl_lo_q[PIO_B_L2_DIR]));
    end
  end

  // Strobe output modes are not built; those modes idle the line high
  always_ff @(posedge clk) begin
    if (rst) begin
      hs2_out_q <= 1'b0;
      hs2_oe_q  <= 1'b0;
    end else begin
      hs2_oe_q  <= ctl_lo_q[PIO_B_L2_DIR];
      hs2_out_q <= ctl_lo_q[PIO_B_L2_LVL] ? ctl_lo_q[PIO_B_L2_IEN] : 1'b1;
    end
  end

  assign s.ctl     = {flag1_q, flag2_q, ctl_lo_q};
  assign s.ddr     = ddr_q;
  assign s.outr    = out_q;
  assign s.irq_n   = irq_n_q;
  assign s.hs2_out = hs2_out_q;
  assign s.hs2_oe  = hs2_oe_q;
  // With the route bit set, output lines read back their latch, input lines the pin; otherwise the direction register
  assign s.rdval   = ctl_lo_q[PIO_B_ROUTE] ? ((ddr_q & out_q) | (~ddr_q & s.pins_s))
                                           : ddr_q;

endmodule : pio_section

// File: logic/pio_top.sv
// Host bus decoder and pin side of the multi-port parallel board
`timescale 1ns/1ps
module pio_top
  import pio_pkg::*;
#(
  parameter int NUM_PORTS = PIO_MAX_PORTS
) (
  input  wire logic                                      clk,
  input  wire logic                                      rst,
  input  wire logic [PIO_AW-1:0]                         addr,
  input  wire logic                                      sinp,
  input  wire logic                                      sout,
  input  wire logic                                      pdbin,
  input  wire logic                                      pwr_n,
  input  wire logic [3:0]                                board_sel,
  input  wire logic [PIO_DW-1:0]                         host_wdata,
  output logic      [PIO_DW-1:0]                         host_rdata_q,
  output logic                                           host_rdata_oe_q,
  input  wire logic [NUM_PORTS*PIO_SEC_PER_PRT-1:0]      hs1_in,
  input  wire logic [NUM_PORTS*PIO_SEC_PER_PRT-1:0]      hs2_in,
  output logic      [NUM_PORTS*PIO_SEC_PER_PRT-1:0]      hs2_out,
  output logic      [NUM_PORTS*PIO_SEC_PER_PRT-1:0]      hs2_oe,
  input  wire logic [NUM_PORTS*PIO_SEC_PER_PRT-1:0][7:0] io_in,
  output logic      [NUM_PORTS*PIO_SEC_PER_PRT-1:0][7:0] io_out,
  output logic      [NUM_PORTS*PIO_SEC_PER_PRT-1:0][7:0] io_oe,
  output logic      [NUM_PORTS*PIO_SEC_PER_PRT-1:0]      irq_n
);

  localparam int NSEC = NUM_PORTS * PIO_SEC_PER_PRT;

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  if (NUM_PORTS < 1 || NUM_PORTS > PIO_MAX_PORTS) begin : g_bad_ports
    $error("NUM_PORTS must be 1 to 4");
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Entry into the active level; a high level held across reset is an event if rising is selected
  function automatic logic edge_into(input logic cur, input logic prev, input logic pol);
    edge_into = pol ? (cur && !prev) : (!cur && prev);
  endfunction : edge_into

  function automatic logic board_hit(input logic [PIO_AW-1:0] a, input logic [3:0] sel);
    logic [1:0] port;
    port      = a[PIO_PORT_MSB:PIO_PORT_LSB];
    board_hit = (a[PIO_BOARD_MSB:PIO_BOARD_LSB] == sel) && (int'(port) < NUM_PORTS);
  endfunction : board_hit

  // ==========================================================================
  // Host strobe edges
  // ==========================================================================
  logic       pdbin_q;
  logic       pwr_n_q;
  logic       hit;
  logic       rd_cycle;
  logic       rd_pulse;
  logic       wr_pulse;
  logic [2:0] sec_idx;
  logic       is_data;

  always_ff @(posedge clk) begin
    if (rst) begin
      pdbin_q <= 1'b0;
      pwr_n_q <= 1'b1;
    end else begin
      pdbin_q <= pdbin;
      pwr_n_q <= pwr_n;
    end
  end

  assign hit      = board_hit(addr, board_sel);
  assign sec_idx  = addr[PIO_SEC_MSB:PIO_SEC_LSB];
  assign is_data  = addr[PIO_CHAN_BIT];
  // Status qualifies the strobe, so memory cycles on the same bus are ignored
  assign rd_cycle = pdbin && sinp && hit;
  assign rd_pulse = rd_cycle && !pdbin_q;
  // Capture on the falling edge of the write strobe while data are stable
  assign wr_pulse = !pwr_n && pwr_n_q && sout && hit;

  // ==========================================================================
  // Sections
  // ==========================================================================
  pio_sec_if sif [NSEC] ();

  logic [NSEC-1:0][7:0] ctl_all;
  logic [NSEC-1:0][7:0] rdv_all;
  logic [NSEC-1:0]      hs1_m_q;
  logic [NSEC-1:0]      hs1_s_q;
  logic [NSEC-1:0]      hs1_p_q;
  logic [NSEC-1:0]      hs2_m_q;
  logic [NSEC-1:0]      hs2_s_q;
  logic [NSEC-1:0]      hs2_p_q;
  logic [NSEC-1:0][7:0] io_m_q;
  logic [NSEC-1:0][7:0] io_s_q;

  // Two-stage synchronisers; only the second stage is looked at
  always_ff @(posedge clk) begin
    if (rst) begin
      hs1_m_q <= '0;
      hs1_s_q <= '0;
      hs2_m_q <= '0;
      hs2_s_q <= '0;
    end else begin
      hs1_m_q <= hs1_in;
      hs1_s_q <= hs1_m_q;
      hs2_m_q <= hs2_in;
      hs2_s_q <= hs2_m_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      io_m_q <= '0;
      io_s_q <= '0;
    end else begin
      io_m_q <= io_in;
      io_s_q <= io_m_q;
    end
  end

  // Previous levels; reset to zero like the synchroniser, so a pin held high gives a rising edge after release
  always_ff @(posedge clk) begin
    if (rst) begin
      hs1_p_q <= '0;
      hs2_p_q <= '0;
    end else begin
      hs1_p_q <= hs1_s_q;
      hs2_p_q <= hs2_s_q;
    end
  end

  for (genvar i = 0; i < NSEC; i++) begin : g_sec
    assign sif[i].wr_ctl  = wr_pulse && (sec_idx == 3'(i)) && !is_data;
    assign sif[i].wr_data = wr_pulse && (sec_idx == 3'(i)) && is_data;
    assign sif[i].rd_data = rd_pulse && (sec_idx == 3'(i)) && is_data;
    assign sif[i].wdata   = host_wdata;
    assign sif[i].pins_s  = io_s_q[i];
    assign sif[i].ev1     = edge_into(hs1_s_q[i], hs1_p_q[i],
                                      sif[i].ctl[PIO_B_L1_LVL]);
    assign sif[i].ev2     = edge_into(hs2_s_q[i], hs2_p_q[i],
                                      sif[i].ctl[PIO_B_L2_LVL]);

    pio_section u_sec (
      .clk (clk),
      .rst (rst),
      .s   (sif[i])
    );

    assign ctl_all[i] = sif[i].ctl;
    assign rdv_all[i] = sif[i].rdval;
    assign io_out[i]  = sif[i].outr;
    assign io_oe[i]   = sif[i].ddr;
    assign irq_n[i]   = sif[i].irq_n;
    assign hs2_out[i] = sif[i].hs2_out;
    assign hs2_oe[i]  = sif[i].hs2_oe;

    // ------------------------------------------------------------------------
    // Checks on this section
    // ------------------------------------------------------------------------
    sequence ctl_write_s;
      sif[i].wr_ctl;
    endsequence

    sequence l1_event_s;
      sif[i].ev1;
    endsequence

    sequence data_read_s;
      sif[i].rd_data && ctl_all[i][PIO_B_ROUTE] && !sif[i].ev1 && !sif[i].ev2;
    endsequence

    ctl_write_keep_a: assert property (@(posedge clk) disable iff (rst)
      ctl_write_s |=> (ctl_all[i][5:0] == $past(host_wdata[5:0])) &&
                      (ctl_all[i][7] == ($past(ctl_all[i][7]) || $past(sif[i].ev1)) ||
                       $past(sif[i].rd_data)))
      else $error("control write disturbed the flags or dropped bits");

    flag_one_set_a: assert property (@(posedge clk) disable iff (rst)
      l1_event_s |=> ctl_all[i][PIO_B_FLAG1])
      else $error("line one activity did not set its flag");

    irq_one_low_a: assert property (@(posedge clk) disable iff (rst)
      (ctl_all[i][PIO_B_FLAG1] && ctl_all[i][PIO_B_L1_IEN]) |=> !irq_n[i])
      else $error("enabled line one flag did not pull the request low");

    irq_disabled_a: assert property (@(posedge clk) disable iff (rst)
      (!ctl_all[i][PIO_B_L1_IEN] && !ctl_all[i][PIO_B_L2_IEN]) |=> irq_n[i])
      else $error("request low with both enables off");

    read_clear_a: assert property (@(posedge clk) disable iff (rst)
      data_read_s |=> !ctl_all[i][PIO_B_FLAG1] ##1 irq_n[i])
      else $error("data read did not clear the flag and request");

    flag_hold_a: assert property (@(posedge clk) disable iff (rst)
      (ctl_all[i][PIO_B_FLAG1] && !(sif[i].rd_data && ctl_all[i][PIO_B_ROUTE]))
        |=> ctl_all[i][PIO_B_FLAG1])
      else $error("line one flag dropped without a data read");

    flag_two_set_a: assert property (@(posedge clk) disable iff (rst)
      (sif[i].ev2 && !ctl_all[i][PIO_B_L2_DIR]) |=> ctl_all[i][PIO_B_FLAG2])
      else $error("line two input activity did not set its flag");

    ddr_route_a: assert property (@(posedge clk) disable iff (rst)
      (sif[i].wr_data && !ctl_all[i][PIO_B_ROUTE])
        |=> (io_oe[i] == $past(host_wdata)) && $stable(io_out[i]))
      else $error("direction write went to the wrong register");

    data_write_a: assert property (@(posedge clk) disable iff (rst)
      (sif[i].wr_data && ctl_all[i][PIO_B_ROUTE]) |=> io_out[i] == $past(host_wdata))
      else $error("data write not captured");

    l2_dir_a: assert property (@(posedge clk) disable iff (rst)
      ctl_all[i][PIO_B_L2_DIR] |=> hs2_oe[i])
      else $error("line two not driven in output direction");

    reset_inputs_a: assert property (@(posedge clk)
      rst |=> (io_oe[i] == PIO_DDR_RST) && !hs2_oe[i])
      else $error("reset left a line driven");

    // Checked against the pin history, not the synchroniser it guards
    edge_detect_a: assert property (@(posedge clk) disable iff (rst)
      sif[i].ev1 |-> ($past(hs1_in[i], 2) == ctl_all[i][PIO_B_L1_LVL]) &&
                     ($past(hs1_in[i], 3) != ctl_all[i][PIO_B_L1_LVL]))
      else $error("line one event without entry into active level");

    flag_two_hold_a: assert property (@(posedge clk) disable iff (rst)
      (ctl_all[i][PIO_B_FLAG2] && !(sif[i].rd_data && ctl_all[i][PIO_B_ROUTE]))
        |=> ctl_all[i][PIO_B_FLAG2])
      else $error("line two flag dropped without a data read");

    irq_two_low_a: assert property (@(posedge clk) disable iff (rst)
      (ctl_all[i][PIO_B_FLAG2] && ctl_all[i][PIO_B_L2_IEN] && !ctl_all[i][PIO_B_L2_DIR])
        |=> !irq_n[i])
      else $error("enabled line two flag did not pull the request low");

    l2_input_a: assert property (@(posedge clk) disable iff (rst)
      !ctl_all[i][PIO_B_L2_DIR] |=> !hs2_oe[i])
      else $error("line two driven while set as an input");

    reset_flags_a: assert property (@(posedge clk)
      rst |=> (ctl_all[i][PIO_CTL_LO_W-1:0] == PIO_CTL_RST) && !ctl_all[i][PIO_B_FLAG1] &&
              (io_out[i] == PIO_OUT_RST) && irq_n[i])
      else $error("reset left a control bit, flag or request active");
  end

  // ==========================================================================
  // Host read data
  // ==========================================================================
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = PIO_RD_IDLE;
    for (int k = 0; k < NSEC; k++) begin
      if (sec_idx == 3'(k)) begin
        rd_mux = is_data ? rdv_all[k] : ctl_all[k];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      host_rdata_q    <= PIO_RD_IDLE;
      host_rdata_oe_q <= 1'b0;
    end else begin
      host_rdata_oe_q <= rd_cycle;
      host_rdata_q    <= rd_cycle ? rd_mux : PIO_RD_IDLE;
    end
  end

  // ==========================================================================
  // Bus-side checks
  // ==========================================================================
  sequence rd_hold_s;
    rd_cycle ##1 rd_cycle;
  endsequence

  read_drive_a: assert property (@(posedge clk) disable iff (rst)
    rd_hold_s |-> host_rdata_oe_q ##1 host_rdata_oe_q)
    else $error("selected read not driven onto the data bus");

  read_release_a: assert property (@(posedge clk) disable iff (rst)
    !pdbin |=> !host_rdata_oe_q)
    else $error("data bus driven without the read strobe");

  board_match_a: assert property (@(posedge clk) disable iff (rst)
    host_rdata_oe_q |-> $past(addr[PIO_BOARD_MSB:PIO_BOARD_LSB]) == $past(board_sel))
    else $error("unselected board answered");

  port_range_a: assert property (@(posedge clk) disable iff (rst)
    (wr_pulse || rd_pulse) |-> int'(addr[PIO_PORT_MSB:PIO_PORT_LSB]) < NUM_PORTS)
    else $error("access decoded to a missing port");

  ctl_read_a: assert property (@(posedge clk) disable iff (rst)
    (rd_cycle && !is_data) |=> host_rdata_q == $past(ctl_all[sec_idx]))
    else $error("control read returned wrong value");

  foreign_write_a: assert property (@(posedge clk) disable iff (rst)
    (!pwr_n && pwr_n_q && (addr[PIO_BOARD_MSB:PIO_BOARD_LSB] != board_sel))
      |=> $stable(io_oe) && $stable(io_out))
    else $error("write to another board changed this board");

  missing_port_a: assert property (@(posedge clk) disable iff (rst)
    (!pwr_n && pwr_n_q && (int'(addr[PIO_PORT_MSB:PIO_PORT_LSB]) >= NUM_PORTS))
      |=> $stable(io_oe) && $stable(io_out))
    else $error("write to a missing port changed a register");

  dir_read_a: assert property (@(posedge clk) disable iff (rst)
    (rd_cycle && is_data && !ctl_all[sec_idx][PIO_B_ROUTE])
      |=> host_rdata_q == $past(io_oe[sec_idx]))
    else $error("direction read returned wrong value");

  // Released bus must not leak stale read data
  idle_rdata_a: assert property (@(posedge clk) disable iff (rst)
    !host_rdata_oe_q |-> host_rdata_q == PIO_RD_IDLE)
    else $error("read data not idle while the bus is released");

endmodule : pio_top

// File: verif/pio_host_model.sv
// Host processor model issuing input and output bus cycles
`timescale 1ns/1ps
module pio_host_model
  import pio_pkg::*;
(
  input  wire logic       clk,
  output logic      [7:0] addr,
  output logic            sinp,
  output logic            sout,
  output logic            pdbin,
  output logic            pwr_n,
  output logic      [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       rdata_oe
);
  initial begin
    addr  = 8'hFF;
    sinp  = 1'b0;
    sout  = 1'b0;
    pdbin = 1'b0;
    pwr_n = 1'b1;
    wdata = 8'h00;
  end
  // ==========================================
  // Bus cycles
  // ==========================================
  // Opcode on the data lines first: the board must not take it without a strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk) wdata = PIO_OP_OUTPUT;
    @(negedge clk) addr = a;
    sout  = 1'b1;
    wdata = v;
    @(negedge clk) pwr_n = 1'b0;
    @(negedge clk) pwr_n = 1'b1;
    sout  = 1'b0;
    wdata = ~v;
    addr  = ~a;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic oe);
    @(negedge clk) wdata = PIO_OP_INPUT;
    @(negedge clk) addr = a;
    sinp = 1'b1;
    // Strobe stands across two edges, so the held-read path is exercised
    @(negedge clk) pdbin = 1'b1;
    repeat (2) @(negedge clk);
    d     = rdata;
    oe    = rdata_oe;
    pdbin = 1'b0;
    sinp  = 1'b0;
    addr  = ~a;
  endtask : rd
endmodule : pio_host_model

// File: verif/test_parallel_io_port_control.sv
// Self-checking bench for the parallel port control block
`timescale 1ns/1ps
module test_parallel_io_port_control;
  import pio_pkg::*;
  localparam int         NP   = 2;
  localparam int         NS   = 2 * NP;
  localparam logic [3:0] BSEL = 4'h1;
  logic                 clk, rst, sinp, sout, pdbin, pwr_n, rdata_oe, oe;
  logic [7:0]           addr, wdata, rdata, d;
  logic [NS-1:0]        hs1_in, hs2_in, hs2_out, hs2_oe, irq_n;
  logic [NS-1:0][7:0]   io_in, io_out, io_oe;
  logic [5:0]           ctl_m [NS];
  logic [7:0]           ddr_m [NS];
  logic [7:0]           out_m [NS];
  logic                 f1 [NS];
  logic                 f2 [NS];
  logic [31:0]          rs, r;
  int                   mismatches = 0;
  int                   n_tests = 0;
  int                   cyc = 0;

  pio_top #(.NUM_PORTS(NP)) dut_u (.clk(clk), .rst(rst), .addr(addr), .sinp(sinp),
    .sout(sout), .pdbin(pdbin), .pwr_n(pwr_n), .board_sel(BSEL), .host_wdata(wdata),
    .host_rdata_q(rdata), .host_rdata_oe_q(rdata_oe), .hs1_in(hs1_in), .hs2_in(hs2_in),
    .hs2_out(hs2_out), .hs2_oe(hs2_oe), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .irq_n(irq_n));
  pio_host_model host_u (.clk(clk), .addr(addr), .sinp(sinp), .sout(sout), .pdbin(pdbin),
    .pwr_n(pwr_n), .wdata(wdata), .rdata(rdata), .rdata_oe(rdata_oe));

  // ==========================================
  // Helpers and reference model
  // ==========================================
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  function automatic logic [7:0] adr(input int i, input logic ch);
    return {BSEL, 2'(i / 2), 1'(i % 2), ch};
  endfunction : adr
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input int i, input logic ch, input logic [7:0] v);
    if (!ch) ctl_m[i] = v[5:0];
    else if (ctl_m[i][PIO_B_ROUTE]) out_m[i] = v;
    else ddr_m[i] = v;
    host_u.wr(adr(i, ch), v);
  endtask : wr
  task automatic rd(input int i, input logic ch);
    logic [7:0] e;
    logic [7:0] m;
    m = ddr_m[i];
    e = !ch ? {f1[i], f2[i], ctl_m[i]} :
        ctl_m[i][PIO_B_ROUTE] ? ((m & out_m[i]) | (~m & io_in[i])) : m;
    host_u.rd(adr(i, ch), d, oe);
    chk(8'(oe), 8'h01);
    chk(d, e);
    if (ch && ctl_m[i][PIO_B_ROUTE]) begin
      f1[i] = 1'b0;
      f2[i] = 1'b0;
    end
  endtask : rd
  task automatic pins(input int i);
    logic [5:0] c;
    c = ctl_m[i];
    repeat (3) @(negedge clk);
    chk(io_oe[i], ddr_m[i]);
    chk(io_out[i], out_m[i]);
    chk(8'(hs2_oe[i]), 8'(c[5]));
    if (c[5]) chk(8'(hs2_out[i]), 8'(c[4] ? c[3] : 1'b1));
    chk(8'(irq_n[i]), 8'(!((f1[i] & c[0]) | (f2[i] & c[3] & !c[5]))));
  endtask : pins
  // Pulse returns idle before any read, so the flag must latch
  task automatic line(input int i, input logic two, input logic lv);
    if (two) hs2_in[i] = lv;
    else hs1_in[i] = lv;
    repeat (3) @(negedge clk);
    if (two) hs2_in[i] = !lv;
    else hs1_in[i] = !lv;
    if (two) f2[i] = 1'b1;
    else f1[i] = 1'b1;
    pins(i);
    rd(i, 1'b0);
  endtask : line
  task automatic close_out();
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  // ==========================================
  // Clock, timeout and main sequence
  // ==========================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Ceiling well above the roughly 500 cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    hs1_in = '1;
    hs2_in = '1;
    io_in = '0;
    rs = 32'd72894;
    for (int i = 0; i < NS; i++) begin
      ctl_m[i] = 6'h00;
      ddr_m[i] = 8'h00;
      out_m[i] = 8'h00;
      f1[i] = 1'b0;
      f2[i] = 1'b0;
    end
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < NS; i++) begin
      pins(i);
      rd(i, 1'b0);
    end
    for (int i = 0; i < NS; i++) begin
      wr(i, 1'b0, 8'hFF);
      pins(i);
      rd(i, 1'b0);
      wr(i, 1'b0, 8'h30);
      pins(i);
      wr(i, 1'b1, 8'(rnd()));
      wr(i, 1'b0, 8'h04);
      wr(i, 1'b1, 8'(rnd()));
      io_in[i] = 8'(rnd());
      pins(i);
      rd(i, 1'b1);
    end
    host_u.wr({~BSEL, 4'h5}, 8'hFF);
    host_u.wr({BSEL, 4'h9}, 8'hFF);
    for (int i = 0; i < NS; i++) pins(i);
    host_u.rd({~BSEL, 4'h1}, d, oe);
    chk(8'(oe), 8'h00);
    host_u.rd({BSEL, 4'hC}, d, oe);
    chk(8'(oe), 8'h00);
    for (int i = 0; i < NS; i++) begin
      r = rnd();
      wr(i, 1'b0, {3'b000, r[4], r[3], 1'b1, r[1], r[0]});
      hs1_in[i] = !r[1];
      hs2_in[i] = !r[4];
      repeat (4) @(negedge clk);
      rd(i, 1'b1);
      line(i, 1'b0, r[1]);
      line(i, 1'b1, r[4]);
      wr(i, 1'b0, {3'b000, r[4], r[3], 1'b0, r[1], r[0]});
      rd(i, 1'b1);
      rd(i, 1'b0);
      wr(i, 1'b0, {3'b000, r[4], r[3], 1'b1, r[1], r[0]});
      rd(i, 1'b1);
      pins(i);
      rd(i, 1'b0);
    end
    close_out();
  end
endmodule : test_parallel_io_port_control
